// *** core/pie_codec.sv ***
// Access-side information element codec: bit-serial receive decoder,
// single-octet element transmitter, APB registers and interrupt.
// Assumes rx bits are synchronous to clk and rx_msg_start marks each message.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - One codeset only; no codeset-shift element is recognised.
// - Identifier bit 8 set means single octet, clear means variable length.
// - Each variable identifier has a length range; undefined identifiers are reserved.
// - After a requested pulse finishes, send the octet C0 to the exchange.
// - The pulse-completion octet names no pulse.
// - Completion is sent only for the latest request that asked notification.
// - Line status uses nibble 1000 plus parameter, only without a signalling path.
// - Line parameter values 0 to 4 are valid, the rest reserved.
// - On request, report the protocol state with nibble 1001.
// - The state element is exactly one octet.
// - States 0 to 7 as binary; 1000 to 1110 unused; 1111 not applicable.
// - Received autonomous-sequence element starts the selected sequence.
// - Sequence type is a plain binary number.
// - Only the access side sends the sequence-result element, nibble 1011.
// - Result type is a plain binary value.
// - Bits go least significant first, octets in ascending order.
// - Each element type at most once per message.
module pie_codec (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_msg_start,
  input  wire logic        path_up,
  input  wire logic [3:0]  fsm_state,
  input  wire logic        pulse_done,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  output logic             seq_start,
  output logic [3:0]       seq_type,
  output logic             irq
);

  // ==========================================================
  // Identifier decode
  function automatic logic [4:0] ie_index(input logic [7:0] id);
    logic [4:0] r;
    r = pie_pkg::PIE_IX_RESV;
    if (id == pie_pkg::PIE_ID_NOTE) r = pie_pkg::PIE_IX_NOTE;
    else if (id[7:4] == pie_pkg::PIE_NIB_LINE) r = pie_pkg::PIE_IX_LINE;
    else if (id[7:4] == pie_pkg::PIE_NIB_STATE) r = pie_pkg::PIE_IX_STATE;
    else if (id[7:4] == pie_pkg::PIE_NIB_AUTO) r = pie_pkg::PIE_IX_AUTO;
    else if (id[7:4] == pie_pkg::PIE_NIB_SRESP) r = pie_pkg::PIE_IX_SRESP;
    for (int i = 5; i < pie_pkg::PIE_NIX; i++) begin
      if (id == pie_pkg::PIE_VAR_ID[i]) r = 5'(i);
    end
    return r;
  endfunction

  // ==========================================================
  // Declarations
  pie_pkg::pie_rx_e        st_r, st_nxt;
  logic [7:0]              rsh_r, rsh_nxt;
  logic [2:0]              rbc_r, rbc_nxt;
  logic [4:0]              idx_r, idx_nxt;
  logic [7:0]              rem_r, rem_nxt;
  logic [2:0]              onum_r, onum_nxt;
  logic                    bad_r, bad_nxt;
  logic                    ask_r, ask_nxt;
  logic                    arm_r, arm_nxt;
  logic                    note_r, note_nxt;
  logic [17:0]             seen_r, seen_nxt;
  logic [7:0]              eid_r, eid_nxt;
  logic                    seq_nxt;
  logic [3:0]              styp_nxt;
  logic                    oct_v;
  logic [7:0]              oct;
  logic [4:0]              oct_ix;
  logic [8:0]              total;
  logic                    err_ev;
  logic                    tbusy_r, tbusy_nxt;
  logic [7:0]              tsh_r, tsh_nxt;
  logic [2:0]              tbc_r, tbc_nxt;
  logic                    take_note;
  logic                    take_cmd;
  logic                    refuse_ev;
  logic                    done_ev;
  logic [7:0]              cmd_oct;
  logic                    cmd_ok;
  logic                    ctrl_r, ctrl_nxt;
  pie_pkg::pie_txcmd_s     cmd_r, cmd_nxt;
  logic                    cpend_r, cpend_nxt;
  logic [4:0]              ist_r, ist_nxt;
  logic [4:0]              imask_r, imask_nxt;
  logic [31:0]             prd_r, prd_nxt;
  logic [4:0]              ev;
  logic                    wr_acc;
  logic                    mapped;

  // ==========================================================
  // Receive deserialiser and element decoder
  assign oct_v  = ctrl_r && rx_bit_valid && !rx_msg_start && (rbc_r == 3'h7);
  assign oct    = {rx_bit, rsh_r[7:1]};
  assign oct_ix = ie_index(oct);
  assign total  = {1'b0, oct} + 9'h002;

  // Decoder next state
  always_comb begin
    logic ask_now;
    ask_now  = ask_r;
    st_nxt   = st_r;
    rsh_nxt  = rsh_r;
    rbc_nxt  = rbc_r;
    idx_nxt  = idx_r;
    rem_nxt  = rem_r;
    onum_nxt = onum_r;
    bad_nxt  = bad_r;
    ask_nxt  = ask_r;
    arm_nxt  = arm_r;
    note_nxt = note_r;
    seen_nxt = seen_r;
    eid_nxt  = eid_r;
    seq_nxt  = 1'b0;
    styp_nxt = seq_type;
    err_ev   = 1'b0;
    if (rx_msg_start) begin
      st_nxt   = pie_pkg::PIE_RX_ID;
      rbc_nxt  = 3'h0;
      seen_nxt = '0;
    end else if (ctrl_r && rx_bit_valid) begin
      rsh_nxt = oct;
      rbc_nxt = rbc_r + 3'h1;
    end
    if (oct_v) begin
      unique case (st_r)
        pie_pkg::PIE_RX_ID: begin
          idx_nxt  = oct_ix;
          onum_nxt = 3'h1;
          ask_nxt  = 1'b0;
          bad_nxt  = (oct_ix == pie_pkg::PIE_IX_RESV) || seen_r[oct_ix];
          if (oct_ix != pie_pkg::PIE_IX_RESV) seen_nxt[oct_ix] = 1'b1;
          if (oct[7]) begin
            if (!bad_nxt && oct_ix == pie_pkg::PIE_IX_AUTO) begin
              seq_nxt  = 1'b1;
              styp_nxt = oct[3:0];
            end else begin
              err_ev = 1'b1;
            end
          end else begin
            st_nxt = pie_pkg::PIE_RX_LEN;
            err_ev = bad_nxt;
          end
          if (err_ev) eid_nxt = oct;
        end
        pie_pkg::PIE_RX_LEN: begin
          if (!bad_r && (total < {1'b0, pie_pkg::PIE_LEN_MIN[idx_r]} ||
                         total > {1'b0, pie_pkg::PIE_LEN_MAX[idx_r]})) begin
            bad_nxt = 1'b1;
            err_ev  = 1'b1;
            eid_nxt = pie_pkg::PIE_VAR_ID[idx_r];
          end
          rem_nxt  = oct;
          onum_nxt = 3'h2;
          st_nxt   = (oct == 8'h00) ? pie_pkg::PIE_RX_ID : pie_pkg::PIE_RX_BODY;
        end
        pie_pkg::PIE_RX_BODY: begin
          if (onum_r != 3'h7) onum_nxt = onum_r + 3'h1;
          if (idx_r == pie_pkg::PIE_IX_PULSED && onum_nxt == pie_pkg::PIE_OCT_ACK_P)
            ask_now = (oct[6:5] != 2'b00);
          if (idx_r == pie_pkg::PIE_IX_DIGIT && onum_nxt == pie_pkg::PIE_OCT_ACK_D)
            ask_now = oct[6];
          ask_nxt = ask_now;
          rem_nxt = rem_r - 8'h01;
          if (rem_r == 8'h01) begin
            st_nxt = pie_pkg::PIE_RX_ID;
            // Latest accepted request decides whether completion is owed
            if (!bad_r && (idx_r == pie_pkg::PIE_IX_PULSED || idx_r == pie_pkg::PIE_IX_DIGIT))
              arm_nxt = ask_now;
          end
        end
        default: st_nxt = pie_pkg::PIE_RX_ID;
      endcase
    end
    // Completion is owed once; a new finish wins over the transmitter taking the old one
    if (take_note) note_nxt = 1'b0;
    if (pulse_done && arm_r) begin
      note_nxt = 1'b1;
      arm_nxt  = 1'b0;
    end
  end

  // Decoder registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= pie_pkg::PIE_RX_ID;
      rsh_r     <= 8'h00;
      rbc_r     <= 3'h0;
      idx_r     <= 5'h00;
      rem_r     <= 8'h00;
      onum_r    <= 3'h0;
      bad_r     <= 1'b0;
      ask_r     <= 1'b0;
      arm_r     <= 1'b0;
      note_r    <= 1'b0;
      seen_r    <= '0;
      eid_r     <= 8'h00;
      seq_start <= 1'b0;
      seq_type  <= 4'h0;
    end else begin
      st_r      <= st_nxt;
      rsh_r     <= rsh_nxt;
      rbc_r     <= rbc_nxt;
      idx_r     <= idx_nxt;
      rem_r     <= rem_nxt;
      onum_r    <= onum_nxt;
      bad_r     <= bad_nxt;
      ask_r     <= ask_nxt;
      arm_r     <= arm_nxt;
      note_r    <= note_nxt;
      seen_r    <= seen_nxt;
      eid_r     <= eid_nxt;
      seq_start <= seq_nxt;
      seq_type  <= styp_nxt;
    end
  end

  // ==========================================================
  // Transmitter: one octet per element, serialised LSB first
  always_comb begin
    cmd_ok  = 1'b1;
    cmd_oct = 8'h00;
    unique case (cmd_r.kind)
      pie_pkg::PIE_K_LINE: begin
        cmd_oct = {pie_pkg::PIE_NIB_LINE, cmd_r.param};
        cmd_ok  = !path_up && (cmd_r.param <= pie_pkg::PIE_LINE_MAX);
      end
      pie_pkg::PIE_K_STATE: begin
        cmd_oct = {pie_pkg::PIE_NIB_STATE, (fsm_state <= pie_pkg::PIE_STATE_MAX) ?
                   fsm_state : pie_pkg::PIE_STATE_NA};
      end
      pie_pkg::PIE_K_SRESP: cmd_oct = {pie_pkg::PIE_NIB_SRESP, cmd_r.param};
      pie_pkg::PIE_K_RESV:  cmd_ok  = 1'b0;
    endcase
  end

  // Transmit next state; completion outranks software commands
  always_comb begin
    tbusy_nxt = tbusy_r;
    tsh_nxt   = tsh_r;
    tbc_nxt   = tbc_r;
    take_note = 1'b0;
    take_cmd  = 1'b0;
    refuse_ev = 1'b0;
    done_ev   = 1'b0;
    if (tbusy_r) begin
      tsh_nxt = {1'b0, tsh_r[7:1]};
      tbc_nxt = tbc_r + 3'h1;
      if (tbc_r == 3'h7) begin
        tbusy_nxt = 1'b0;
        done_ev   = 1'b1;
      end
    end else if (ctrl_r && note_r) begin
      take_note = 1'b1;
      tbusy_nxt = 1'b1;
      tsh_nxt   = pie_pkg::PIE_ID_NOTE;
      tbc_nxt   = 3'h0;
    end else if (ctrl_r && cpend_r) begin
      take_cmd  = 1'b1;
      refuse_ev = !cmd_ok;
      tbusy_nxt = cmd_ok;
      tsh_nxt   = cmd_ok ? cmd_oct : tsh_r;
      tbc_nxt   = 3'h0;
    end
  end

  // Transmit registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tbusy_r <= 1'b0;
      tsh_r   <= 8'h00;
      tbc_r   <= 3'h0;
    end else begin
      tbusy_r <= tbusy_nxt;
      tsh_r   <= tsh_nxt;
      tbc_r   <= tbc_nxt;
    end
  end

  assign tx_bit       = tsh_r[0];
  assign tx_bit_valid = tbusy_r;

  // ==========================================================
  // APB slave, zero wait states, read data captured in setup
  assign wr_acc  = psel && penable && pwrite;
  assign mapped  = (paddr == pie_pkg::PIE_OFF_CTRL) || (paddr == pie_pkg::PIE_OFF_TXCMD) ||
                   (paddr == pie_pkg::PIE_OFF_STATUS) || (paddr == pie_pkg::PIE_OFF_IST) ||
                   (paddr == pie_pkg::PIE_OFF_IMASK);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prd_r;
  assign ev      = {refuse_ev, done_ev, take_note, err_ev, seq_nxt};
  assign irq     = |(ist_r & imask_r);

  // Register next state; a new event wins over a write-one clear
  always_comb begin
    ctrl_nxt  = ctrl_r;
    cmd_nxt   = cmd_r;
    cpend_nxt = cpend_r;
    imask_nxt = imask_r;
    ist_nxt   = ist_r;
    prd_nxt   = prd_r;
    if (take_cmd) cpend_nxt = 1'b0;
    if (wr_acc && paddr == pie_pkg::PIE_OFF_CTRL) ctrl_nxt = pwdata[0];
    if (wr_acc && paddr == pie_pkg::PIE_OFF_IMASK) imask_nxt = pwdata[4:0];
    if (wr_acc && paddr == pie_pkg::PIE_OFF_TXCMD && !cpend_r) begin
      cmd_nxt   = pie_pkg::pie_txcmd_s'(pwdata[5:0]);
      cpend_nxt = 1'b1;
    end
    if (wr_acc && paddr == pie_pkg::PIE_OFF_IST) ist_nxt = ist_r & ~pwdata[4:0];
    ist_nxt = ist_nxt | ev;
    if (psel && !penable) begin
      unique case (paddr)
        pie_pkg::PIE_OFF_CTRL:   prd_nxt = {31'h0, ctrl_r};
        pie_pkg::PIE_OFF_TXCMD:  prd_nxt = {26'h0, cmd_r};
        pie_pkg::PIE_OFF_STATUS: prd_nxt = {8'h00, eid_r, 4'h0, seq_type,
                                            4'h0, note_r, arm_r, cpend_r, tbusy_r};
        pie_pkg::PIE_OFF_IST:    prd_nxt = {27'h0, ist_r};
        pie_pkg::PIE_OFF_IMASK:  prd_nxt = {27'h0, imask_r};
        default:                 prd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register file
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r  <= pie_pkg::PIE_CTRL_RST;
      cmd_r   <= '0;
      cpend_r <= 1'b0;
      ist_r   <= 5'h00;
      imask_r <= 5'h00;
      prd_r   <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cmd_r   <= cmd_nxt;
      cpend_r <= cpend_nxt;
      ist_r   <= ist_nxt;
      imask_r <= imask_nxt;
      prd_r   <= prd_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_note_octet: assert property (take_note |=> tx_bit_valid && tsh_r == 8'hC0)
    else $error("completion octet not loaded");
  chk_note_armed: assert property ($rose(note_r) |-> $past(arm_r) && $past(pulse_done))
    else $error("completion raised without armed request");
  chk_line_code: assert property (take_cmd && cmd_r.kind == pie_pkg::PIE_K_LINE && cmd_ok
    |=> tsh_r[7:4] == 4'h8 && tsh_r[3:0] <= 4'h4 && !$past(path_up))
    else $error("bad line status octet");
  chk_state_code: assert property (take_cmd && cmd_r.kind == pie_pkg::PIE_K_STATE
    |=> tsh_r[7:4] == 4'h9 && (tsh_r[3:0] <= 4'h7 || tsh_r[3:0] == 4'hF))
    else $error("bad state octet");
  chk_octet_frame: assert property ($rose(tx_bit_valid) |-> tx_bit_valid[*8] ##1 !tx_bit_valid)
    else $error("element not one octet");
  chk_no_auto_tx: assert property ($rose(tx_bit_valid) |-> tsh_r[7:4] != 4'hA)
    else $error("autonomous sequence transmitted");
  chk_lsb_first: assert property ($rose(tx_bit_valid) ##1 1 |-> tx_bit == $past(tsh_r[1]))
    else $error("serial order wrong");
  chk_seq_start: assert property (oct_v && st_r == pie_pkg::PIE_RX_ID && oct[7:4] == 4'hA
    && !seen_r[pie_pkg::PIE_IX_AUTO] |=> seq_start && seq_type == $past(oct[3:0]))
    else $error("sequence not started");
  chk_dup_err: assert property (oct_v && st_r == pie_pkg::PIE_RX_ID && oct_ix != 5'h1F
    && seen_r[oct_ix] |=> !seq_start && ist_r[1])
    else $error("duplicate element accepted");
  chk_resv_err: assert property (oct_v && st_r == pie_pkg::PIE_RX_ID && oct_ix == 5'h1F
    |-> err_ev ##1 (ist_r[1] && eid_r == $past(oct)))
    else $error("reserved identifier not flagged");

  cov_seq_start: cover property (seq_start);
  cov_note_sent: cover property (take_note ##[1:20] done_ev);
  cov_refused:   cover property (refuse_ev);
  cov_len_error: cover property (err_ev && st_r == pie_pkg::PIE_RX_LEN);

endmodule

`default_nettype wire

// *** include/pie_pkg.sv ***
// Constants and types shared by the telephony element codec.
// Assumes one 100 MHz clock domain and an APB register bus.
`default_nettype none
package pie_pkg;

  // ==========================================================
  // Register map and fields
  localparam logic [7:0] PIE_OFF_CTRL   = 8'h00;
  localparam logic [7:0] PIE_OFF_TXCMD  = 8'h04;
  localparam logic [7:0] PIE_OFF_STATUS = 8'h08;
  localparam logic [7:0] PIE_OFF_IST    = 8'h0C;
  localparam logic [7:0] PIE_OFF_IMASK  = 8'h10;
  localparam int         PIE_NEV        = 5;
  localparam int         PIE_EV_SEQ     = 0;
  localparam int         PIE_EV_ERR     = 1;
  localparam int         PIE_EV_NOTE    = 2;
  localparam int         PIE_EV_TXDONE  = 3;
  localparam int         PIE_EV_REFUSE  = 4;
  localparam logic       PIE_CTRL_RST   = 1'b0;

  // ==========================================================
  // Identifier coding
  localparam logic [7:0] PIE_ID_NOTE    = 8'hC0;
  localparam logic [3:0] PIE_NIB_LINE   = 4'h8;
  localparam logic [3:0] PIE_NIB_STATE  = 4'h9;
  localparam logic [3:0] PIE_NIB_AUTO   = 4'hA;
  localparam logic [3:0] PIE_NIB_SRESP  = 4'hB;
  localparam logic [3:0] PIE_LINE_MAX   = 4'h4;
  localparam logic [3:0] PIE_STATE_MAX  = 4'h7;
  localparam logic [3:0] PIE_STATE_NA   = 4'hF;
  localparam logic [4:0] PIE_IX_NOTE    = 5'h00;
  localparam logic [4:0] PIE_IX_LINE    = 5'h01;
  localparam logic [4:0] PIE_IX_STATE   = 5'h02;
  localparam logic [4:0] PIE_IX_AUTO    = 5'h03;
  localparam logic [4:0] PIE_IX_SRESP   = 5'h04;
  localparam logic [4:0] PIE_IX_PULSED  = 5'h07;
  localparam logic [4:0] PIE_IX_DIGIT   = 5'h09;
  localparam logic [4:0] PIE_IX_RESV    = 5'h1F;
  localparam int         PIE_NIX        = 18;
  localparam logic [2:0] PIE_OCT_ACK_P  = 3'h5;
  localparam logic [2:0] PIE_OCT_ACK_D  = 3'h3;
  // Variable-length identifiers, by index 5 to 17
  localparam logic [17:0][7:0] PIE_VAR_ID = {8'h24, 8'h23, 8'h22, 8'h14, 8'h13, 8'h12, 8'h11,
                                             8'h10, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00, {5{8'hFF}}};
  localparam logic [17:0][7:0] PIE_LEN_MIN = {8'h03, 8'h04, 8'h04, 8'h03, 8'h03, 8'h03, 8'h04,
                                              8'h04, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, {5{8'h01}}};
  localparam logic [17:0][7:0] PIE_LEN_MAX = {8'hFF, 8'h05, 8'h07, 8'h08, 8'h05, 8'h03, 8'h06,
                                              8'h04, 8'h03, 8'h03, 8'h05, 8'h03, 8'h03, {5{8'h01}}};

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PIE_RX_ID   = 2'b00,
    PIE_RX_LEN  = 2'b01,
    PIE_RX_BODY = 2'b10
  } pie_rx_e;

  typedef enum logic [1:0] {
    PIE_K_LINE  = 2'b00,
    PIE_K_STATE = 2'b01,
    PIE_K_SRESP = 2'b10,
    PIE_K_RESV  = 2'b11
  } pie_kind_e;

  typedef struct packed {
    pie_kind_e  kind;
    logic [3:0] param;
  } pie_txcmd_s;

endpackage

`default_nettype wire

// *** sim/pie_exch_model.sv ***
// Exchange-side peer: sends element octets, collects access-side octets.
// Assumes tasks are called by the bench; clk is the codec clock.
`timescale 1ns/100ps
`default_nettype none
module pie_exch_model (
  input  wire logic clk,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      rx_msg_start
);
  logic [7:0] sh;
  logic [7:0] got;
  int         cnt;
  int         n_got;
  initial begin
    {rx_bit, rx_bit_valid, rx_msg_start} = 3'h0;
    cnt = 0;
    n_got = 0;
  end
  // ==========================================================
  // Receive: first bit on the wire is bit 1 of the octet
  always @(posedge clk) begin
    if (tx_bit_valid === 1'b1) begin
      sh = {tx_bit, sh[7:1]};
      cnt++;
      if (cnt == 8) begin
        got = sh;
        n_got++;
        cnt = 0;
      end
    end
  end
  // ==========================================================
  // Send one message of single-codeset octets, LSB first, then release
  task msg(input logic [7:0] q[$]);
    @(posedge clk);
    rx_msg_start <= 1'b1;
    @(posedge clk);
    rx_msg_start <= 1'b0;
    foreach (q[k]) begin
      for (int i = 0; i < 8; i++) begin
        rx_bit <= q[k][i];
        rx_bit_valid <= 1'b1;
        @(posedge clk);
      end
    end
    rx_bit_valid <= 1'b0;
    rx_bit <= ~rx_bit; // Idle line shows no stale value
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the element codec.
// Assumes the exchange model drives the serial link.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        rxb, rxv, rxs, path_up, pulse_done, txb, txv, seq_start, irq, e;
  logic [3:0]  fsm_state, seq_type;
  int          error_cnt, n_compared, cyc;
  pie_codec pie_codec_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_bit(rxb), .rx_bit_valid(rxv), .rx_msg_start(rxs),
    .path_up(path_up), .fsm_state(fsm_state), .pulse_done(pulse_done), .tx_bit(txb),
    .tx_bit_valid(txv), .seq_start(seq_start), .seq_type(seq_type), .irq(irq));
  pie_exch_model pie_exch_model_inst (.clk(clk), .tx_bit(txb), .tx_bit_valid(txv),
    .rx_bit(rxb), .rx_bit_valid(rxv), .rx_msg_start(rxs));
  // ==========================================================
  // Clock, timeout
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  // ==========================================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // Wait ends on the first rising edge that sees pready high; pready is tied high, so one access cycle
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  task clr;
    apb(1'b1, pie_pkg::PIE_OFF_IST, 32'h1F);
  endtask
  task tx_exp(input logic [7:0] x, input logic hit);
    int n0, n;
    n0 = pie_exch_model_inst.n_got;
    for (n = 0; n < 40 && pie_exch_model_inst.n_got == n0; n++) @(negedge clk);
    chk("tx octet seen", 32'(pie_exch_model_inst.n_got - n0), 32'(hit));
    if (hit) chk("tx octet", {24'h0, pie_exch_model_inst.got}, {24'h0, x});
    // Return on a rising edge so that following stimulus lands there
    @(posedge clk);
  endtask
  // Received element must raise only the error event and record its identifier
  task err_case(input logic [7:0] m[$], input logic [7:0] id);
    pie_exch_model_inst.msg(m);
    repeat (3) @(negedge clk);
    rd(pie_pkg::PIE_OFF_IST, 32'h2, "ist rx error");
    rd(pie_pkg::PIE_OFF_STATUS, {8'h00, id, 16'h0500}, "error id");
    clr;
  endtask
  task cmd(input pie_pkg::pie_kind_e k, input logic [3:0] p);
    apb(1'b1, pie_pkg::PIE_OFF_TXCMD, {26'h0, pie_pkg::pie_txcmd_s'{k, p}});
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    rd(pie_pkg::PIE_OFF_CTRL, 32'h0, "ctrl");
    rd(pie_pkg::PIE_OFF_STATUS, 32'h0, "status");
    rd(pie_pkg::PIE_OFF_IST, 32'h0, "ist");
    rd(pie_pkg::PIE_OFF_IMASK, 32'h0, "imask");
    rd(8'h14, 32'h0, "unmapped");
    chk("slverr", {31'h0, e}, 32'h1);
    apb(1'b1, pie_pkg::PIE_OFF_CTRL, 32'h1);
    apb(1'b1, pie_pkg::PIE_OFF_IMASK, 32'h1F);
    $display("test regs done");
  endtask
  task t_seq;
    int hit;
    hit = 0;
    pie_exch_model_inst.msg('{8'hA5});
    repeat (6) begin
      @(negedge clk);
      hit += (seq_start === 1'b1);
    end
    chk("seq pulses", 32'(hit), 32'h1);
    chk("seq type", {28'h0, seq_type}, 32'h5);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(pie_pkg::PIE_OFF_IST, 32'h1, "ist seq");
    clr;
    @(negedge clk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    $display("test sequence done");
  endtask
  task t_err;
    logic [7:0] bad[4] = '{8'hC0, 8'h85, 8'h93, 8'hB2};
    foreach (bad[i]) begin
      err_case('{bad[i]}, bad[i]);
    end
    // Reserved variable identifier, short length, repeated element
    err_case('{8'h05, 8'h01, 8'h00}, 8'h05);
    err_case('{8'h02, 8'h00}, 8'h02);
    err_case('{8'h00, 8'h01, 8'h07, 8'h00, 8'h01, 8'h07}, 8'h00);
    chk("seq type kept", {28'h0, seq_type}, 32'h5);
    $display("test rx errors done");
  endtask
  task t_tx;
    for (int p = 0; p < 5; p++) begin
      cmd(pie_pkg::PIE_K_LINE, 4'(p));
      tx_exp({4'h8, 4'(p)}, 1'b1);
    end
    fsm_state <= 4'h7;
    cmd(pie_pkg::PIE_K_STATE, 4'h0);
    tx_exp(8'h97, 1'b1);
    fsm_state <= 4'h9;
    cmd(pie_pkg::PIE_K_STATE, 4'h0);
    tx_exp(8'h9F, 1'b1);
    cmd(pie_pkg::PIE_K_SRESP, 4'hD);
    tx_exp(8'hBD, 1'b1);
    clr;
    cmd(pie_pkg::PIE_K_LINE, 4'h5);
    tx_exp(8'h0, 1'b0);
    cmd(pie_pkg::PIE_K_RESV, 4'h0);
    path_up <= 1'b1;
    cmd(pie_pkg::PIE_K_LINE, 4'h1);
    tx_exp(8'h0, 1'b0);
    rd(pie_pkg::PIE_OFF_IST, 32'h10, "ist refused");
    path_up <= 1'b0;
    clr;
    $display("test transmit done");
  endtask
  task t_note;
    pie_exch_model_inst.msg('{8'h02, 8'h03, 8'hFF, 8'h80, 8'hA0});
    @(posedge clk);
    pulse_done <= 1'b1;
    @(posedge clk);
    pulse_done <= 1'b0;
    tx_exp(8'hC0, 1'b1);
    rd(pie_pkg::PIE_OFF_IST, 32'hC, "ist note");
    pie_exch_model_inst.msg('{8'h02, 8'h03, 8'hFF, 8'h80, 8'hA0});
    pie_exch_model_inst.msg('{8'h02, 8'h03, 8'hFF, 8'h80, 8'h80});
    @(posedge clk);
    pulse_done <= 1'b1;
    @(posedge clk);
    pulse_done <= 1'b0;
    tx_exp(8'h0, 1'b0);
    // Digit-signal element asking notification arms completion too
    pie_exch_model_inst.msg('{8'h04, 8'h01, 8'hC5});
    @(posedge clk);
    pulse_done <= 1'b1;
    @(posedge clk);
    pulse_done <= 1'b0;
    tx_exp(8'hC0, 1'b1);
    $display("test completion done");
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {path_up, pulse_done, fsm_state} = '0;
    {error_cnt, n_compared, cyc} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_seq;
    t_err;
    t_tx;
    t_note;
    final_report;
  end
endmodule
`default_nettype wire
